// File: verilog/asr_readout.sv
// Serial result readout with conversion sequencing and oversampling control.
// Overview of operation
// - Each channel result is sixteen bits, shifted out over sixteen serial clocks.
// - Following sixteen-clock groups return further channels in ascending channel number.
// - Line A sends the first channel set, then the second set.
// - Line B sends the second set first, then the first set.
// - Serial mode uses chip select, serial clock, busy, first flag, two data lines.
// - Reads while busy is high return the previous sample set.
// - Oversample select pins are captured at busy falling, used for next conversion.
// - Busy duration grows with the selected oversampling ratio.
// - All serial transfers are referenced to the serial clock rising edge.
// - Chip select falling starts a new frame at the first channel result.
// - After chip select rises, the next serial clock rising edge places all data outputs in high impedance.
// - Start input A drives channels one to four, B channels five to eight.
`timescale 1ns/1ps
module asr_readout
    import asr_pkg::*;
#(
    parameter int CONV_CYC = asr_pkg::CONV_BASE_CYC
) (
    // System side.
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // Conversion control pins.
    input  wire logic                          convert_start_a,
    input  wire logic                          convert_start_b,
    input  wire logic [asr_pkg::OSR_W-1:0]     oversample_select,
    output logic                               busy,
    output logic [asr_pkg::OSR_W-1:0]          oversample_ratio,
    // Sample data from the converter core, one word per channel.
    input  wire logic [asr_pkg::SAMPLE_W-1:0]  sample_data [asr_pkg::CHAN_N],
    // Serial link, clocked by the host.
    input  wire logic                          sclk,
    input  wire logic                          cs_n,
    output logic                               serial_out_a,
    output logic                               serial_out_a_oe,
    output logic                               serial_out_b,
    output logic                               serial_out_b_oe,
    output logic                               first_channel_flag
);
    import asr_pkg::*;

    // Pin synchronisers into the mclk domain.
    logic [1:0] sa_sync, sb_sync;
    logic [OSR_W-1:0] os_s1, os_s2;
    always_ff @(posedge mclk) begin
        sa_sync <= srst ? 2'h0 : {sa_sync[0], convert_start_a};
        sb_sync <= srst ? 2'h0 : {sb_sync[0], convert_start_b};
        os_s1   <= srst ? OSR_RESET : oversample_select;
        os_s2   <= srst ? OSR_RESET : os_s1;
    end
    logic sa_d, sb_d;
    always_ff @(posedge mclk) begin
        sa_d <= srst ? 1'b0 : sa_sync[1];
        sb_d <= srst ? 1'b0 : sb_sync[1];
    end
    wire start_a_rise = sa_sync[1] & ~sa_d;
    wire start_b_rise = sb_sync[1] & ~sb_d;

    // Conversion sequencer: busy lasts CONV_CYC shifted left by the ratio.
    asr_conv_state_t state, next_state;
    logic [31:0] conv_cnt;
    logic [SET_N*2-1:0] pend;
    logic [SAMPLE_W-1:0] held [CHAN_N];
    logic [SAMPLE_W-1:0] result [CHAN_N];
    wire [31:0] conv_len = 32'(CONV_CYC) << oversample_ratio;
    wire conv_done = (conv_cnt + 32'h1 >= conv_len);
    wire start_any = start_a_rise | start_b_rise;
    always_comb begin
        case (state)
            ASR_IDLE:    next_state = start_any ? ASR_CONVERT : ASR_IDLE;
            ASR_CONVERT: next_state = conv_done ? ASR_UPDATE : ASR_CONVERT;
            ASR_UPDATE:  next_state = ASR_IDLE;
            default:     next_state = ASR_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            state            <= ASR_IDLE;
            conv_cnt         <= 32'h0;
            busy             <= 1'b0;
            oversample_ratio <= OSR_RESET;
            pend             <= 8'h00;
        end else begin
            state    <= next_state;
            conv_cnt <= (state == ASR_CONVERT) ? conv_cnt + 32'h1 : 32'h0;
            busy     <= (next_state == ASR_CONVERT);
            if (state == ASR_CONVERT && conv_done) begin
                oversample_ratio <= os_s2;
            end
            if (state == ASR_IDLE && start_any) begin
                pend <= {{SET_N{start_b_rise}}, {SET_N{start_a_rise}}};
            end else if (state == ASR_UPDATE) begin
                pend <= 8'h00;
            end
        end
    end
    // Track and hold: channels sample on their set's start edge.
    always_ff @(posedge mclk) begin
        for (int i = 0; i < CHAN_N; i++) begin
            if (srst) begin
                held[i]   <= SAMPLE_RESET;
                result[i] <= SAMPLE_RESET;
            end else begin
                if (state == ASR_IDLE && ((i < SET_N) ? start_a_rise : start_b_rise)) begin
                    held[i] <= sample_data[i];
                end
                if (state == ASR_UPDATE && pend[i]) begin
                    result[i] <= held[i];
                end
            end
        end
    end

    // Result words cross to the link as a toggle-handshaked snapshot.
    // Only a fresh result set is sent, but the buffer can hold an older copy ahead of a newer one until chip select goes high.
    logic [SAMPLE_W*CHAN_N-1:0] snap;
    logic snap_tgl;
    logic snap_due;
    logic snap_ack, snap_ack1, snap_ack2;
    wire  snap_send = snap_due && (state == ASR_IDLE) && !busy && (snap_ack2 == snap_tgl);
    always_ff @(posedge mclk) begin
        if (srst) begin
            snap     <= '0;
            snap_tgl <= 1'b0;
        end else if (snap_send) begin
            for (int i = 0; i < CHAN_N; i++) begin
                snap[i*SAMPLE_W +: SAMPLE_W] <= result[i];
            end
            snap_tgl <= ~snap_tgl;
        end
    end
    // A completed conversion marks the result set as due for the link.
    always_ff @(posedge mclk) begin
        if (srst) begin
            snap_due <= 1'b0;
        end else if (state == ASR_UPDATE) begin
            snap_due <= 1'b1;
        end else if (snap_send) begin
            snap_due <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        snap_ack1 <= srst ? 1'b0 : snap_ack;
        snap_ack2 <= srst ? 1'b0 : snap_ack1;
    end

    // Link domain: reset is srst synchronised to sclk; frame start comes from chip select.
    logic [1:0] lrst_sync;
    logic [1:0] tgl_sync;
    logic cs_d;
    always_ff @(posedge sclk) begin
        lrst_sync <= {lrst_sync[0], srst};
        tgl_sync  <= {tgl_sync[0], snap_tgl};
        cs_d      <= cs_n;
    end
    wire lrst = lrst_sync[1];
    logic [SAMPLE_W*CHAN_N-1:0] frame;
    // Two-entry buffer holding snapshots; link drains only between frames.
    logic [SAMPLE_W*CHAN_N-1:0] buf_mem [2];
    logic [1:0] wr_ptr, rd_ptr;
    wire buf_full    = (wr_ptr[1] != rd_ptr[1]) && (wr_ptr[0] == rd_ptr[0]);
    wire buf_empty   = (wr_ptr == rd_ptr);
    wire in_valid    = (tgl_sync[1] != snap_ack);
    wire in_ready    = ~buf_full;
    wire frame_start = cs_d & ~cs_n;
    wire out_ready   = cs_n;
    wire out_valid   = ~buf_empty;
    always_ff @(posedge sclk) begin
        if (lrst) begin
            wr_ptr   <= 2'h0;
            rd_ptr   <= 2'h0;
            snap_ack <= 1'b0;
            frame    <= '0;
        end else begin
            if (in_valid && in_ready) begin
                buf_mem[wr_ptr[0]] <= snap;
                wr_ptr             <= wr_ptr + 2'h1;
                snap_ack           <= ~snap_ack;
            end
            if (out_valid && out_ready) begin
                frame  <= buf_mem[rd_ptr[0]];
                rd_ptr <= rd_ptr + 2'h1;
            end
        end
    end

    // Serial shifter, all updates on the sclk rising edge.
    logic [BIT_CNT_W-1:0]  bit_cnt;
    logic [CHAN_CNT_W-1:0] chan_cnt;
    wire [CHAN_CNT_W-1:0] chan_a = chan_cnt;
    wire [CHAN_CNT_W-1:0] chan_b = chan_cnt ^ CHAN_CNT_W'(SET_N);
    wire [CHAN_CNT_W-1:0] next_chan = (bit_cnt == 4'hF) ? chan_cnt + 3'h1 : chan_cnt;
    wire [BIT_CNT_W-1:0]  cur_bit  = frame_start ? 4'h0 : bit_cnt;
    wire [CHAN_CNT_W-1:0] cur_chan = frame_start ? 3'h0 : chan_cnt;
    wire [SAMPLE_W-1:0] word_a = frame[(cur_chan) * SAMPLE_W +: SAMPLE_W];
    wire [SAMPLE_W-1:0] word_b = frame[(cur_chan ^ CHAN_CNT_W'(SET_N)) * SAMPLE_W +: SAMPLE_W];
    wire [BIT_CNT_W-1:0] msb_idx = 4'hF - cur_bit;
    always_ff @(posedge sclk) begin
        if (lrst || cs_n) begin
            bit_cnt            <= 4'h0;
            chan_cnt           <= 3'h0;
            serial_out_a_oe    <= 1'b0;
            serial_out_b_oe    <= 1'b0;
            serial_out_a       <= 1'b0;
            serial_out_b       <= 1'b0;
            first_channel_flag <= 1'b0;
        end else begin
            bit_cnt            <= cur_bit + 4'h1;
            chan_cnt           <= frame_start ? ((cur_bit == 4'hF) ? 3'h1 : 3'h0) : next_chan;
            serial_out_a_oe    <= 1'b1;
            serial_out_b_oe    <= 1'b1;
            serial_out_a       <= word_a[msb_idx];
            serial_out_b       <= word_b[msb_idx];
            first_channel_flag <= (cur_chan == 3'h0);
        end
    end
    wire unused_ab = ^{chan_a, chan_b};

    // Checks.
    // Helper counters: length of the busy pulse and of the first-channel flag run.
    logic [31:0] busy_len;
    always_ff @(posedge mclk) begin
        busy_len <= (srst || !busy) ? 32'h0 : busy_len + 32'h1;
    end
    logic [4:0] flag_run;
    always_ff @(posedge sclk) begin
        flag_run <= (lrst || !first_channel_flag) ? 5'h00 : flag_run + 5'h01;
    end
    a_busy_ratio_len: assert property (@(posedge mclk) disable iff (srst)
        $fell(busy) |-> busy_len == $past(conv_len)) else $error("busy length does not follow the ratio");
    a_osr_capture: assert property (@(posedge mclk) disable iff (srst)
        $fell(busy) |-> oversample_ratio == $past(os_s2)) else $error("ratio not captured at busy fall");
    a_result_hold: assert property (@(posedge mclk) disable iff (srst)
        busy |=> $stable(result[0])) else $error("results changed while busy");
    a_hiz_on_deselect: assert property (@(posedge sclk) disable iff (lrst)
        cs_n |=> !serial_out_a_oe && !serial_out_b_oe) else $error("outputs driven while deselected");
    a_frame_first: assert property (@(posedge sclk) disable iff (lrst)
        frame_start |=> first_channel_flag) else $error("frame did not start at first channel");
    a_flag_len: assert property (@(posedge sclk) disable iff (lrst)
        flag_run <= 5'h10) else $error("first flag longer than sixteen clocks");
    a_bit_wrap: assert property (@(posedge sclk) disable iff (lrst)
        (!cs_n && !frame_start && bit_cnt == 4'hF) |=> chan_cnt == $past(chan_cnt) + 3'h1)
        else $error("channel did not advance after sixteen bits");
    a_set_swap: assert property (@(posedge sclk) disable iff (lrst)
        (chan_b ^ chan_a) == 3'h4) else $error("line b set order wrong");
endmodule

// File: verilog/asr_pkg.sv
// Package of constants and types for the serial readout and oversampling block.
package asr_pkg;
    localparam int          SAMPLE_W       = 16;
    localparam int          CHAN_N         = 8;
    localparam int          SET_N          = 4;
    localparam int          BIT_CNT_W      = 4;
    localparam int          CHAN_CNT_W     = 3;
    localparam int          OSR_W          = 3;
    localparam int          CONV_BASE_NS   = 4000;
    localparam int          CLK_NS         = 8;
    localparam int          CONV_BASE_CYC  = (CONV_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  OSR_RESET      = 3'h0;
    localparam logic [15:0] SAMPLE_RESET   = 16'h0000;
    typedef enum logic [1:0] {ASR_IDLE, ASR_CONVERT, ASR_UPDATE} asr_conv_state_t;
endpackage

// File: sim/asr_host.sv
// Host model that frames and clocks results out of the serial link.
`timescale 1ns/1ps
module asr_host (
    // Link pins.
    output logic      sclk,
    output logic      cs_n,
    input  wire logic serial_out_a,
    input  wire logic serial_out_a_oe,
    input  wire logic serial_out_b,
    input  wire logic serial_out_b_oe,
    input  wire logic first_channel_flag
);
    logic [33:0] got;
    logic        idle_oe;
    event        word_done;
    initial {sclk, cs_n} = 2'h1;
    // The link clock rests low; bits are taken at each falling edge, when they have settled.
    task automatic pulse();
        #7.5;
        sclk = 1'b1;
        #7.5;
        sclk = 1'b0;
    endtask
    task automatic read_frame(input int words);
        // Idle clocks with chip select high let a fresh snapshot reach the frame register.
        repeat (8) pulse();
        cs_n = 1'b0;
        for (int b = 0; b < 16 * words; b++) begin
            pulse();
            if (b % 16 == 0) got[33:32] = {first_channel_flag, serial_out_a_oe & serial_out_b_oe};
            got[31:0] = {got[30:16], serial_out_a, got[14:0], serial_out_b};
            if (b % 16 == 15) -> word_done;
        end
        cs_n = 1'b1;
        repeat (3) pulse();
        idle_oe = serial_out_a_oe | serial_out_b_oe;
    endtask
endmodule

// File: sim/asr_readout_test.sv
// Self-checking bench for the serial readout and oversampling block.
`timescale 1ns/1ps
module asr_readout_test;
    import asr_pkg::*;
    localparam int CONV = 32;
    logic        mclk = 1'b0;
    logic        srst, convert_start_a, convert_start_b, busy, sclk, cs_n;
    logic        out_a, oe_a, out_b, oe_b, flag;
    logic [2:0]  oversample_select, oversample_ratio, ratio, sel;
    logic [15:0] sample_data [CHAN_N];
    logic [15:0] prev [CHAN_N];
    logic [33:0] exp_q [$];
    int          bad_count = 0, n_compared = 0, cyc = 0, n;
    asr_readout #(.CONV_CYC(CONV)) dut_u (.mclk, .srst, .convert_start_a, .convert_start_b, .oversample_select,
        .busy, .oversample_ratio, .sample_data, .sclk, .cs_n, .serial_out_a(out_a), .serial_out_a_oe(oe_a),
        .serial_out_b(out_b), .serial_out_b_oe(oe_b), .first_channel_flag(flag));
    asr_host host_u (.sclk, .cs_n, .serial_out_a(out_a), .serial_out_a_oe(oe_a), .serial_out_b(out_b),
        .serial_out_b_oe(oe_b), .first_channel_flag(flag));
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) close_out(1);
    end
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic cmp(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Each word carries flag, both enables, line A and line B; B runs half a frame ahead.
    task automatic frame(input logic [15:0] d [CHAN_N], input int words);
        for (int w = 0; w < words; w++) exp_q.push_back({w == 0, 1'b1, d[w], d[(w + 4) % 8]});
        host_u.read_frame(words);
        cmp(34'h0, {33'h0, host_u.idle_oe});
    endtask
    task automatic close_out(input int extra);
        bad_count += extra;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial forever begin
        @(host_u.word_done);
        if (exp_q.size() > 0) cmp(exp_q.pop_front(), host_u.got);
    end
    initial begin
        {srst, convert_start_a, convert_start_b, oversample_select, ratio} = {1'b1, 2'h0, 3'h0, OSR_RESET};
        foreach (sample_data[c]) sample_data[c] = SAMPLE_RESET;
        prev = sample_data;
        void'($urandom(32'hCAFADC71));
        fork
            repeat (16) tick();
            repeat (6) host_u.pulse();
        join
        srst = 1'b0;
        cmp(34'h0, {30'h0, oe_a, oe_b, flag, busy});
        repeat (3) tick();
        for (int t = 0; t < 3; t++) begin
            sel = 3'($urandom);
            foreach (sample_data[c]) sample_data[c] = 16'($urandom);
            oversample_select = sel;
            {convert_start_a, convert_start_b} = 2'h3;
            for (n = 0; busy !== 1'b1 && n < 10; n++) tick();
            {convert_start_a, convert_start_b} = 2'h0;
            fork
                for (n = 0; busy === 1'b1 && n < 5000; n++) tick();
                frame(prev, 8);
            join
            cmp(34'(CONV << ratio), 34'(n));
            cmp({31'h0, sel}, {31'h0, oversample_ratio});
            ratio = sel;
            frame(sample_data, 3);
            frame(sample_data, 8);
            prev = sample_data;
            $display("test %0d done, ratio %0d", t, sel);
        end
        cmp(34'h0, 34'(exp_q.size()));
        close_out(0);
    end
endmodule
